/* core/tcp_pkg.sv */
/*
  Constants for the capture/compare timer channel pair: register offsets,
  field positions, reset values and mode codes.
  Assumes a 32-bit APB slave with word-aligned byte addresses.
*/
package tcp_pkg;
  // Register byte offsets
  localparam logic [7:0] TCP_OFS_CTRL = 8'h00;
  localparam logic [7:0] TCP_OFS_OPT = 8'h04;
  localparam logic [7:0] TCP_OFS_OVF_CLR = 8'h08;
  localparam logic [7:0] TCP_OFS_CNT = 8'h0C;
  localparam logic [7:0] TCP_OFS_CCR0 = 8'h10;
  localparam logic [7:0] TCP_OFS_CCR1 = 8'h14;
  localparam logic [7:0] TCP_OFS_EDGE = 8'h18;
  localparam logic [7:0] TCP_OFS_OUTC = 8'h1C;
  localparam logic [7:0] TCP_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] TCP_OFS_IRQ_MASK = 8'h24;

  // Control register fields
  localparam int TCP_CTRL_MODE_LSB = 0;
  localparam int TCP_CTRL_EXT_CLK = 6;
  localparam int TCP_CTRL_RUN = 7;
  localparam int TCP_CTRL_W = 8;

  // Option register fields
  localparam int TCP_OPT_OVF = 0;
  localparam int TCP_OPT_ROLE0 = 4;
  localparam int TCP_OPT_ROLE1 = 5;

  // Interrupt status bits
  localparam int TCP_IRQ_CC0 = 0;
  localparam int TCP_IRQ_CC1 = 1;
  localparam int TCP_IRQ_OVF = 2;
  localparam int TCP_IRQ_W = 3;

  // Edge selection codes, two bits per pin
  localparam logic [1:0] TCP_EDGE_NONE = 2'h0;
  localparam logic [1:0] TCP_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCP_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCP_EDGE_BOTH = 2'h3;

  // Mode field codes
  localparam logic [2:0] TCP_MODE_FREE = 3'h5;
  localparam logic [2:0] TCP_MODE_PULSE = 3'h6;

  // Counter values and reset values
  localparam logic [15:0] TCP_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TCP_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TCP_CCR_RST = 16'h0000;
  localparam logic [7:0] TCP_BYTE_RST = 8'h00;
  localparam logic [31:0] TCP_WORD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    TCP_ST_IDLE = 3'b001,
    TCP_ST_FREE = 3'b010,
    TCP_ST_PULSE = 3'b100
  } tcp_state_type;
endpackage

/* core/tcp_edge_detect.sv */
/*
  Valid-edge detector for one capture trigger pin.
  Assumes the pin is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module tcp_edge_detect
  import tcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pin and selection
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  // Results
  output logic valid_edge,
  output logic rise
);
  logic pin_prev;
  wire fall;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin;
    end
  end

  assign rise = pin & ~pin_prev;
  assign fall = ~pin & pin_prev;

  always_comb begin
    unique case (edge_sel)
      TCP_EDGE_NONE: valid_edge = 1'b0;
      TCP_EDGE_RISE: valid_edge = rise;
      TCP_EDGE_FALL: valid_edge = fall;
      TCP_EDGE_BOTH: valid_edge = rise | fall;
    endcase
  end
endmodule // tcp_edge_detect

/* core/tcp_timer.sv */
/*
  Sixteen-bit timer with two capture/compare channels, free-running and
  pulse-width measurement modes, overflow flag and interrupt logic, APB slave.
  Assumes trigger pins synchronous to ref_clk and an APB master on ref_clk.
*/
// Chosen here: the placing of the registers and the APB register port.
// Function
// - Mode code 110 selects pulse-width measurement
// - Counter counts once run bit set
// - Edge captures count, interrupts; clears counter in pulse-width mode only
// - Overflow after FFFFH: interrupt, wrap, flag
// - External clock on pin zero, measure pin one
// - Output control ignored in pulse-width mode
// - Flag cleared by bit clear or write
// - Bit clear loses to simultaneous overflow
// - Counter read returns live count harmlessly
// - Mode code 101 selects free-running operation
// - Role bit picks compare or capture
`timescale 1ns/1ps
module tcp_timer
  import tcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture trigger pins
  input wire logic trigger_pin_zero,
  input wire logic trigger_pin_one,
  // Timer outputs and events
  output logic [1:0] timer_out,
  output logic [1:0] capture_compare_irq,
  output logic overflow_irq,
  output logic irq
);
  // Register state
  logic [TCP_CTRL_W-1:0] timer_control_reg0;
  logic overflow_flag;
  logic [1:0] role_select;
  logic [15:0] counter;
  logic [15:0] capture_compare_reg [2];
  logic [3:0] edge_select_reg;
  logic [3:0] output_control_reg;
  logic [TCP_IRQ_W-1:0] irq_status;
  logic [TCP_IRQ_W-1:0] irq_mask;
  tcp_state_type state;
  tcp_state_type next_state;

  // APB decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire access = psel & penable;
  wire wr_en = access & pready & pwrite;
  wire rd_setup = access & ~pready;
  wire mapped = hit(paddr, TCP_OFS_CTRL) | hit(paddr, TCP_OFS_OPT) |
    hit(paddr, TCP_OFS_OVF_CLR) | hit(paddr, TCP_OFS_CNT) |
    hit(paddr, TCP_OFS_CCR0) | hit(paddr, TCP_OFS_CCR1) |
    hit(paddr, TCP_OFS_EDGE) | hit(paddr, TCP_OFS_OUTC) |
    hit(paddr, TCP_OFS_IRQ_STAT) | hit(paddr, TCP_OFS_IRQ_MASK);
  wire wr_ctrl = wr_en & hit(paddr, TCP_OFS_CTRL);
  wire wr_opt = wr_en & hit(paddr, TCP_OFS_OPT);
  wire wr_ovf_clr = wr_en & hit(paddr, TCP_OFS_OVF_CLR) & pwdata[TCP_OPT_OVF];
  wire wr_ccr0 = wr_en & hit(paddr, TCP_OFS_CCR0);
  wire wr_ccr1 = wr_en & hit(paddr, TCP_OFS_CCR1);
  wire wr_edge = wr_en & hit(paddr, TCP_OFS_EDGE);
  wire wr_outc = wr_en & hit(paddr, TCP_OFS_OUTC);
  wire wr_stat = wr_en & hit(paddr, TCP_OFS_IRQ_STAT);
  wire wr_mask = wr_en & hit(paddr, TCP_OFS_IRQ_MASK);

  // Control fields
  wire [2:0] mode_select_field = timer_control_reg0[TCP_CTRL_MODE_LSB +: 3];
  wire run_control_bit = timer_control_reg0[TCP_CTRL_RUN];
  wire ext_clk_sel = timer_control_reg0[TCP_CTRL_EXT_CLK];
  wire [1:0] pin0_edge_sel = edge_select_reg[1:0];
  wire [1:0] pin1_edge_sel = edge_select_reg[3:2];

  // Edge detection
  wire [1:0] valid_edge;
  wire [1:0] pin_rise;

  tcp_edge_detect u_edge0 (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin(trigger_pin_zero),
    .edge_sel(pin0_edge_sel),
    .valid_edge(valid_edge[0]),
    .rise(pin_rise[0])
  );

  tcp_edge_detect u_edge1 (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin(trigger_pin_one),
    .edge_sel(pin1_edge_sel),
    .valid_edge(valid_edge[1]),
    .rise(pin_rise[1])
  );

  // Mode state
  always_comb begin
    next_state = TCP_ST_IDLE;
    if (run_control_bit && mode_select_field == TCP_MODE_FREE) begin
      next_state = TCP_ST_FREE;
    end else if (run_control_bit && mode_select_field == TCP_MODE_PULSE) begin
      next_state = TCP_ST_PULSE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= TCP_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire running = (state != TCP_ST_IDLE);
  wire pulse_mode = (state == TCP_ST_PULSE);
  wire free_mode = (state == TCP_ST_FREE);

  // Count clock: ref_clk, or rising edges on pin zero when external
  wire tick = running & (ext_clk_sel ? pin_rise[0] : 1'b1);
  wire wrap = tick & (counter == TCP_CNT_MAX);

  // Pin zero never captures while it carries the external count clock
  wire [1:0] cap_edge = valid_edge & {1'b1, ~ext_clk_sel};

  // Per-channel capture and compare events
  wire [1:0] capture_ev;
  wire [1:0] compare_ev;
  wire [1:0] chan_ev;
  wire pulse_clear = pulse_mode & (|capture_ev);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // Capture in pulse mode, or in free mode with capture role
      assign capture_ev[ch] = running & cap_edge[ch] &
        (pulse_mode | role_select[ch]);
      // Compare fires on the count following the match
      assign compare_ev[ch] = free_mode & ~role_select[ch] & tick &
        (counter == capture_compare_reg[ch]);
      assign chan_ev[ch] = capture_ev[ch] | compare_ev[ch];
    end
  endgenerate

  // Counter
  logic [15:0] next_counter;

  always_comb begin
    next_counter = counter;
    if (!running) begin
      next_counter = TCP_CNT_ZERO;
    end else if (pulse_clear) begin
      next_counter = TCP_CNT_ZERO;
    end else if (wrap) begin
      next_counter = TCP_CNT_ZERO;
    end else if (tick) begin
      next_counter = counter + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter <= TCP_CNT_ZERO;
    end else begin
      counter <= next_counter;
    end
  end

  // Capture/compare registers: capture beats a software write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      capture_compare_reg[0] <= TCP_CCR_RST;
      capture_compare_reg[1] <= TCP_CCR_RST;
    end else begin
      if (capture_ev[0]) begin
        capture_compare_reg[0] <= counter;
      end else if (wr_ccr0) begin
        capture_compare_reg[0] <= pwdata[15:0];
      end
      if (capture_ev[1]) begin
        capture_compare_reg[1] <= counter;
      end else if (wr_ccr1) begin
        capture_compare_reg[1] <= pwdata[15:0];
      end
    end
  end

  // Overflow flag: write of zero wins, bit clear loses to set
  logic next_overflow_flag;

  always_comb begin
    next_overflow_flag = overflow_flag;
    if (wr_ovf_clr) begin
      next_overflow_flag = 1'b0;
    end
    if (wrap) begin
      next_overflow_flag = 1'b1;
    end
    if (wr_opt && !pwdata[TCP_OPT_OVF]) begin
      next_overflow_flag = 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_control_reg0 <= TCP_BYTE_RST;
      role_select <= 2'b00;
      edge_select_reg <= 4'h0;
      output_control_reg <= 4'h0;
      irq_mask <= '0;
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
      if (wr_ctrl) begin
        timer_control_reg0 <= pwdata[TCP_CTRL_W-1:0];
      end
      if (wr_opt) begin
        role_select <= {pwdata[TCP_OPT_ROLE1], pwdata[TCP_OPT_ROLE0]};
      end
      if (wr_edge) begin
        edge_select_reg <= pwdata[3:0];
      end
      if (wr_outc) begin
        output_control_reg <= pwdata[3:0];
      end
      if (wr_mask) begin
        irq_mask <= pwdata[TCP_IRQ_W-1:0];
      end
    end
  end

  // Interrupt status: sticky, write one to clear, set wins
  wire [TCP_IRQ_W-1:0] irq_set = {wrap, chan_ev[1], chan_ev[0]};
  wire [TCP_IRQ_W-1:0] irq_clr = wr_stat ? pwdata[TCP_IRQ_W-1:0] : '0;
  wire [TCP_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_status <= '0;
      irq <= 1'b0;
      capture_compare_irq <= 2'b00;
      overflow_irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
      capture_compare_irq <= chan_ev;
      overflow_irq <= wrap;
    end
  end

  // Timer outputs: level in bits 1:0, enable in bits 3:2
  wire [1:0] out_level = output_control_reg[1:0];
  wire [1:0] out_enable = output_control_reg[3:2];
  wire start = run_control_bit & (state == TCP_ST_IDLE) & (next_state == TCP_ST_FREE);
  logic [1:0] next_timer_out;

  always_comb begin
    next_timer_out = timer_out;
    if (pulse_mode) begin
      next_timer_out = 2'b00;
    end else if (!free_mode && !start) begin
      next_timer_out = out_level;
    end else begin
      next_timer_out = timer_out ^ (out_enable & (compare_ev | {2{start}}));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_out <= 2'b00;
    end else begin
      timer_out <= next_timer_out;
    end
  end

  // Read mux
  logic [31:0] rd_data;

  always_comb begin
    rd_data = TCP_WORD_ZERO;
    if (hit(paddr, TCP_OFS_CTRL)) begin
      rd_data[TCP_CTRL_W-1:0] = timer_control_reg0;
    end
    if (hit(paddr, TCP_OFS_OPT)) begin
      rd_data[TCP_OPT_OVF] = overflow_flag;
      rd_data[TCP_OPT_ROLE0] = role_select[0];
      rd_data[TCP_OPT_ROLE1] = role_select[1];
    end
    if (hit(paddr, TCP_OFS_CNT)) begin
      rd_data[15:0] = counter;
    end
    if (hit(paddr, TCP_OFS_CCR0)) begin
      rd_data[15:0] = capture_compare_reg[0];
    end
    if (hit(paddr, TCP_OFS_CCR1)) begin
      rd_data[15:0] = capture_compare_reg[1];
    end
    if (hit(paddr, TCP_OFS_EDGE)) begin
      rd_data[3:0] = edge_select_reg;
    end
    if (hit(paddr, TCP_OFS_OUTC)) begin
      rd_data[3:0] = output_control_reg;
    end
    if (hit(paddr, TCP_OFS_IRQ_STAT)) begin
      rd_data[TCP_IRQ_W-1:0] = irq_status;
    end
    if (hit(paddr, TCP_OFS_IRQ_MASK)) begin
      rd_data[TCP_IRQ_W-1:0] = irq_mask;
    end
  end

  // APB answer: one wait state, data and error registered
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= TCP_WORD_ZERO;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~mapped;
      if (rd_setup && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end
endmodule // tcp_timer

/* sim/tcp_timer_properties.sv */
/*
  Checker for the timer pair ports: APB answer timing, interrupt ties,
  pulse-mode capture and output quieting.
  Assumes binding to tcp_timer; mirrors written control, edge and mask.
*/
`timescale 1ns/1ps
module tcp_timer_properties
  import tcp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic trigger_pin_zero,
  input wire logic trigger_pin_one,
  input wire logic [1:0] timer_out,
  input wire logic [1:0] capture_compare_irq,
  input wire logic overflow_irq,
  input wire logic irq
);
  logic [7:0] ctrl;
  logic [3:0] edge_q;
  logic [2:0] mask;
  wire wr_hit = psel && penable && pready && pwrite;
  wire pulse_mode = ctrl[2:0] == TCP_MODE_PULSE;
  wire pulse_run = pulse_mode && ctrl[TCP_CTRL_RUN];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= TCP_BYTE_RST;
      edge_q <= 4'h0;
      mask <= 3'h0;
    end else if (wr_hit) begin
      if (paddr == TCP_OFS_CTRL) ctrl <= pwdata[7:0];
      if (paddr == TCP_OFS_EDGE) edge_q <= pwdata[3:0];
      if (paddr == TCP_OFS_IRQ_MASK) mask <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_ready_timing: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_gated: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == TCP_WORD_ZERO)
    else $error("refused read data not zero");
  a_ovf_single_pulse: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow pulse too long");
  a_ovf_irq_tie: assert property (overflow_irq && mask[TCP_IRQ_OVF] |-> irq)
    else $error("overflow did not raise irq");
  a_cap_irq_tie: assert property (capture_compare_irq[1] && mask[TCP_IRQ_CC1] |-> irq)
    else $error("capture did not raise irq");
  a_irq_masked: assert property (mask == 3'h0 && $past(mask) == 3'h0 |-> !irq)
    else $error("irq high while all masked");
  // Output clears two edges after the mode lands: state register, then output flop
  a_pulse_out_low: assert property (pulse_run && $past(pulse_run)
    && $past(pulse_run, 2) |-> timer_out == 2'b00)
    else $error("timer output active in pulse mode");
  a_pulse_capture: assert property (pulse_run && $past(pulse_run)
    && edge_q[3:2] == TCP_EDGE_RISE && $rose(trigger_pin_one)
    |-> ##[1:3] capture_compare_irq[1])
    else $error("edge not captured");
endmodule // tcp_timer_properties

bind tcp_timer tcp_timer_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pin_zero(trigger_pin_zero),
  .trigger_pin_one(trigger_pin_one), .timer_out(timer_out),
  .capture_compare_irq(capture_compare_irq), .overflow_irq(overflow_irq), .irq(irq));

/* sim/tcp_pulse_src.sv */
/*
  External pulse source on the two capture trigger pins.
  Assumes commands from the bench synchronous to ref_clk.
*/
`timescale 1ns/1ps
module tcp_pulse_src (
  // Clock
  input wire logic ref_clk,
  // Command
  input wire logic go,
  input wire logic [7:0] gap,
  input wire logic [3:0] n_edges,
  // Pins
  output logic trigger_pin_zero,
  output logic trigger_pin_one,
  output logic busy
);
  logic [7:0] phase = 8'h00;
  logic [3:0] left = 4'h0;
  wire last = phase == gap - 8'd1;
  assign busy = left != 4'h0;
  // Pin zero stays low, its edge detection is left off
  assign trigger_pin_zero = 1'b0;
  // Four high cycles opening each period, one rise per period
  assign trigger_pin_one = busy && phase < 8'd4;
  always @(posedge ref_clk) begin
    if (go) begin
      left <= n_edges;
      phase <= 8'h00;
    end else if (busy) begin
      phase <= last ? 8'h00 : phase + 8'd1;
      if (last) left <= left - 4'd1;
    end
  end
endmodule // tcp_pulse_src

/* sim/test_timer_capture_pulse_width.sv */
/*
  Self-checking bench for tcp_timer: register reset and access, pulse-width
  capture, free-running compare, overflow flag and interrupt.
  Assumes tcp_pulse_src on the pins and the bound checker.
*/
`timescale 1ns/1ps
module test_timer_capture_pulse_width;
  import tcp_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, go, busy;
  logic [7:0] paddr, gap, g;
  logic [31:0] pwdata, prdata, v, r;
  logic pin0, pin1, overflow_irq, irq;
  logic [1:0] timer_out, capture_compare_irq;
  logic [3:0] n_edges;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  integer seed;
  int i, error_cnt = 0, n_checks = 0;
  int cyc = 0, ce = 0;
  logic [15:0] p;
  // Free edge count, for captures and the wrap edge
  always @(posedge ref_clk) cyc <= cyc + 1;
  wire [2:0] ev = {overflow_irq, capture_compare_irq};
  tcp_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_pin_zero(pin0), .trigger_pin_one(pin1),
    .timer_out(timer_out), .capture_compare_irq(capture_compare_irq),
    .overflow_irq(overflow_irq), .irq(irq));
  tcp_pulse_src u_src (.ref_clk(ref_clk), .go(go), .gap(gap), .n_edges(n_edges),
    .trigger_pin_zero(pin0), .trigger_pin_one(pin1), .busy(busy));
  task automatic check(input logic [32:0] exp, input logic [32:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] x);
    int k;
    if (!w) exp_q.push_back(x);
    // One idle edge, so no signal is driven twice in a time step
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    check(33'(k < 20), 33'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, TCP_WORD_ZERO, {1'b0, d});
  endtask
  task automatic wait_for(input int which, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ev[which] !== 1'b1 && k < lim);
    check(33'(k < lim), 33'h1);
  endtask
  // Read monitor: oldest expectation against each answered read
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_FFFF_FFFF;
      check(e, {pslverr, prdata});
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
  initial begin
    seed = 32'h8f7b;
    {sys_rst, psel, penable, pwrite, go} = 5'b10000;
    {paddr, pwdata, gap, n_edges} = '0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i++) rd(8'(i * 4), TCP_WORD_ZERO);
    apb(1'b0, 8'h28, TCP_WORD_ZERO, {1'b1, TCP_WORD_ZERO});
    v = $random(seed);
    wr(TCP_OFS_CCR0, v);
    wr(TCP_OFS_CCR1, ~v);
    wr(TCP_OFS_CNT, v);
    rd(TCP_OFS_CCR0, {16'h0000, v[15:0]});
    rd(TCP_OFS_CCR1, {16'h0000, ~v[15:0]});
    rd(TCP_OFS_CNT, TCP_WORD_ZERO);
    $display("test registers done");
    wr(TCP_OFS_EDGE, {28'h0, TCP_EDGE_RISE, TCP_EDGE_NONE});
    wr(TCP_OFS_OUTC, 32'h0000_000F);
    wr(TCP_OFS_IRQ_MASK, 32'h0000_0002);
    wr(TCP_OFS_CTRL, {24'h0, 5'h10, TCP_MODE_PULSE});
    r = $random(seed);
    g = 8'd20 + 8'(r[5:0]);
    gap <= g;
    n_edges <= 4'd4;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    wait_for(1, 300);
    for (i = 0; i < 3; i++) begin
      wait_for(1, 300);
      rd(TCP_OFS_CNT, 32'h0000_0003);
      rd(TCP_OFS_CCR1, {24'h0, g - 8'd1});
    end
    check(33'(timer_out), 33'h0);
    check(33'(irq), 33'h1);
    $display("test pulse width done");
    wr(TCP_OFS_CTRL, TCP_WORD_ZERO);
    wr(TCP_OFS_EDGE, TCP_WORD_ZERO);
    wr(TCP_OFS_OPT, 32'h0000_0020);
    wr(TCP_OFS_CCR0, 32'h0000_003F);
    wr(TCP_OFS_IRQ_MASK, TCP_WORD_ZERO);
    wr(TCP_OFS_IRQ_STAT, 32'h0000_0007);
    wr(TCP_OFS_CTRL, {24'h0, 5'h10, TCP_MODE_FREE});
    wait_for(0, 200);
    ce = cyc;
    check(33'(timer_out), 33'h1);
    rd(TCP_OFS_IRQ_STAT, 32'h0000_0001);
    check(33'(irq), 33'h0);
    wr(TCP_OFS_IRQ_STAT, 32'h0000_0001);
    rd(TCP_OFS_IRQ_STAT, TCP_WORD_ZERO);
    // Free-running capture on pin one, counter keeps running
    wr(TCP_OFS_EDGE, {28'h0, TCP_EDGE_RISE, TCP_EDGE_NONE});
    n_edges <= 4'd2;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    wait_for(1, 300);
    p = 16'(cyc - ce + 32'h0000_003F);
    rd(TCP_OFS_CCR1, {16'h0000, p});
    wait_for(1, 300);
    rd(TCP_OFS_CCR1, {16'h0000, p + 16'(g)});
    wr(TCP_OFS_IRQ_STAT, 32'h0000_0002);
    $display("test compare done");
    wr(TCP_OFS_OPT, 32'h0000_0030);
    wr(TCP_OFS_IRQ_MASK, 32'h0000_0004);
    // Bit clear lands on the wrap edge, four edges after its call
    while (cyc - ce < 32'h0000_FFBB) @(posedge ref_clk);
    wr(TCP_OFS_OVF_CLR, 32'h0000_0001);
    wait_for(2, 70000);
    check(33'(irq), 33'h1);
    rd(TCP_OFS_OPT, 32'h0000_0031);
    rd(TCP_OFS_IRQ_STAT, 32'h0000_0004);
    wr(TCP_OFS_IRQ_MASK, TCP_WORD_ZERO);
    wr(TCP_OFS_OVF_CLR, 32'h0000_0001);
    rd(TCP_OFS_OPT, 32'h0000_0030);
    check(33'(irq), 33'h0);
    wr(TCP_OFS_IRQ_STAT, 32'h0000_0004);
    rd(TCP_OFS_IRQ_STAT, TCP_WORD_ZERO);
    $display("test overflow done");
    results();
  end
endmodule // test_timer_capture_pulse_width
